// >>> etc_pkg.sv
// package for the eight-bit timer with compare units
package etc_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // word byte addresses of the register map
  localparam logic [4:0] ADR_CTRL_A = 5'h00;
  localparam logic [4:0] ADR_CTRL_B = 5'h04;
  localparam logic [4:0] ADR_COUNT = 5'h08;
  localparam logic [4:0] ADR_CMP_A = 5'h0C;
  localparam logic [4:0] ADR_CMP_B = 5'h10;
  localparam logic [4:0] ADR_MASK = 5'h14;
  localparam logic [4:0] ADR_FLAG = 5'h18;
  // control register a fields
  localparam int CA_WGM0 = 0;
  localparam int CA_WGM1 = 1;
  localparam int CA_COMB_LO = 4;
  localparam int CA_COMA_LO = 6;
  // control register b fields
  localparam int CB_CS_LO = 0;
  localparam int CB_WGM2 = 3;
  // flag and mask bit positions
  localparam int FL_OVF = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_CMPB = 2;
  // clock source select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_M8 = 10'h007;
  localparam logic [9:0] PRE_M64 = 10'h03F;
  localparam logic [9:0] PRE_M256 = 10'h0FF;
  localparam logic [9:0] PRE_M1024 = 10'h3FF;
  // waveform mode codes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PC_A = 3'h5;
  localparam logic [2:0] WM_FAST_A = 3'h7;
  // compare output mode codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] waveform_mode;
    logic [2:0] clock_source_select;
  } etc_ctrl_t;
endpackage : etc_pkg

// >>> etc_timer.sv
// eight-bit timer/counter with two compare units and wishbone registers
`timescale 1ns/1ps
module etc_timer #(
  parameter int WIDTH = etc_pkg::DATA_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic timer_power_reduction,
  input wire logic external_count_pin,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  output logic compare_output_pin_a,
  output logic compare_output_pin_b,
  output logic bottom,
  output logic top
);
  etc_pkg::etc_ctrl_t ctrl;
  logic [WIDTH-1:0] counter_value;
  logic [WIDTH-1:0] compare_value_a;
  logic [WIDTH-1:0] compare_value_b;
  logic [WIDTH-1:0] buffer_a;
  logic [WIDTH-1:0] buffer_b;
  logic [2:0] timer_mask_register;
  logic [2:0] timer_flag_register;
  logic count_down;
  logic [etc_pkg::PRE_W-1:0] prescale;
  logic [2:0] pin_sync;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic tick;
  logic block_match;
  logic match_a;
  logic match_b;
  logic pend_a;
  logic pend_b;
  logic buffered;
  logic phase_correct;
  logic top_is_a;
  logic [WIDTH-1:0] top_value;
  logic [WIDTH-1:0] next_count;
  logic next_down;
  logic ovf_event;
  logic at_top;
  logic at_bottom;
  logic access;
  logic wr;
  logic wr_lane0;
  logic hit;
  logic wr_count;
  logic [7:0] wdata;
  logic enabled;

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign hit = (wb_adr_i[31:5] == 27'h0000000) & (wb_adr_i[1:0] == 2'h0)
      & (wb_adr_i[4:2] <= 3'h6);
  assign wr = access & hit & wb_we_i;
  assign wr_lane0 = wr & wb_sel_i[0];
  assign wdata = wb_dat_i[7:0];
  assign wr_count = wr_lane0 & (wb_adr_i[4:0] == etc_pkg::ADR_COUNT);
  // power reduction held high clears and holds the prescaler at zero and blocks every tick; bus writes still reach the registers
  assign enabled = ~timer_power_reduction;

  // mode decode
  assign buffered = ctrl.waveform_mode[0];
  assign phase_correct = (ctrl.waveform_mode == etc_pkg::WM_PC_FF)
      | (ctrl.waveform_mode == etc_pkg::WM_PC_A);
  assign top_is_a = (ctrl.waveform_mode == etc_pkg::WM_CTC)
      | ctrl.waveform_mode[2];
  assign top_value = top_is_a ? compare_value_a : etc_pkg::CNT_MAX;
  assign at_bottom = (counter_value == etc_pkg::CNT_BOTTOM);
  assign at_top = (counter_value == top_value);
  assign bottom = at_bottom;
  assign top = (counter_value == etc_pkg::CNT_MAX);
  assign match_a = (counter_value == compare_value_a);
  assign match_b = (counter_value == compare_value_b);

  // prescaler free-runs; tick per selected source
  always_ff @(posedge core_clk) begin
    if (rst | ~enabled) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // three-stage sampling of the pin; stage 0 read only by stage 1
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], external_count_pin};
    end
  end

  // new level accepted only once stages 1 and 2 agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_level <= 1'b0;
    end else if (pin_sync[2] == pin_sync[1]) begin
      pin_level <= pin_sync[2];
    end
  end

  assign pin_rise = pin_sync[2] & pin_sync[1] & ~pin_level;
  assign pin_fall = ~pin_sync[2] & ~pin_sync[1] & pin_level;

  always_comb begin
    case (ctrl.clock_source_select)
      etc_pkg::CS_STOP: tick = 1'b0;
      etc_pkg::CS_DIV1: tick = 1'b1;
      etc_pkg::CS_DIV8: tick = (prescale[2:0] == etc_pkg::PRE_M8[2:0]);
      etc_pkg::CS_DIV64: tick = (prescale[5:0] == etc_pkg::PRE_M64[5:0]);
      etc_pkg::CS_DIV256: tick = (prescale[7:0] == etc_pkg::PRE_M256[7:0]);
      etc_pkg::CS_DIV1024: tick = (prescale == etc_pkg::PRE_M1024);
      etc_pkg::CS_EXT_FALL: tick = pin_fall;
      etc_pkg::CS_EXT_RISE: tick = pin_rise;
      default: tick = 1'b0;
    endcase
    if (!enabled) begin
      tick = 1'b0;
    end
  end

  // next counter value and direction per mode
  always_comb begin
    next_count = counter_value;
    next_down = count_down;
    ovf_event = 1'b0;
    if (phase_correct) begin
      if (count_down) begin
        next_count = counter_value - 8'h01;
        if (counter_value == 8'h01 || at_bottom) begin
          next_down = 1'b0;
          ovf_event = 1'b1;
        end
      end else begin
        next_count = counter_value + 8'h01;
        if (counter_value + 8'h01 >= top_value || at_top) begin
          next_down = 1'b1;
        end
      end
      if (at_top && !count_down) begin
        next_count = counter_value - 8'h01;
      end
    end else if (at_top && top_is_a) begin
      next_count = etc_pkg::CNT_BOTTOM;
      next_down = 1'b0;
      ovf_event = ctrl.waveform_mode[0]; // fast pwm overflows at top
    end else begin
      next_count = counter_value + 8'h01;
      next_down = 1'b0;
      ovf_event = (counter_value == etc_pkg::CNT_MAX);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      counter_value <= etc_pkg::RST_BYTE;
      count_down <= 1'b0;
    end else if (wr_count) begin
      counter_value <= wdata;
    end else if (tick) begin
      counter_value <= next_count;
      count_down <= next_down;
    end
  end

  // a counter write hides matches for one timer tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      block_match <= 1'b0;
    end else if (wr_count) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // match latched on tick, flag set at the following tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end else if (tick) begin
      pend_a <= match_a & ~block_match & ~wr_count;
      pend_b <= match_b & ~block_match & ~wr_count;
    end
  end

  // control, mask and compare registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= '0;
      timer_mask_register <= 3'h0;
      buffer_a <= etc_pkg::RST_BYTE;
      buffer_b <= etc_pkg::RST_BYTE;
    end else if (wr_lane0) begin
      case (wb_adr_i[4:0])
        etc_pkg::ADR_CTRL_A: begin
          ctrl.waveform_mode[1:0] <= {wdata[etc_pkg::CA_WGM1],
              wdata[etc_pkg::CA_WGM0]};
          ctrl.com_a <= wdata[etc_pkg::CA_COMA_LO +: 2];
          ctrl.com_b <= wdata[etc_pkg::CA_COMB_LO +: 2];
        end
        etc_pkg::ADR_CTRL_B: begin
          ctrl.waveform_mode[2] <= wdata[etc_pkg::CB_WGM2];
          ctrl.clock_source_select <= wdata[etc_pkg::CB_CS_LO +: 3];
        end
        etc_pkg::ADR_CMP_A: buffer_a <= wdata;
        etc_pkg::ADR_CMP_B: buffer_b <= wdata;
        etc_pkg::ADR_MASK: timer_mask_register <= wdata[2:0];
        default: ;
      endcase
    end
  end

  // active compare registers: direct when unbuffered, else at top/bottom
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_value_a <= etc_pkg::RST_BYTE;
      compare_value_b <= etc_pkg::RST_BYTE;
    end else if (!buffered) begin
      compare_value_a <= buffer_a;
      compare_value_b <= buffer_b;
    end else if (tick && (phase_correct ? at_top : at_bottom)) begin
      compare_value_a <= buffer_a;
      compare_value_b <= buffer_b;
    end
  end

  // flags: set wins over any clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_flag_register <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_lane0 && wb_adr_i[4:0] == etc_pkg::ADR_FLAG && wdata[i]) begin
          timer_flag_register[i] <= 1'b0;
        end else if (irq_ack[i]) begin
          timer_flag_register[i] <= 1'b0;
        end
      end
      if (tick && ovf_event) begin
        timer_flag_register[etc_pkg::FL_OVF] <= 1'b1;
      end
      if (tick && pend_a) begin
        timer_flag_register[etc_pkg::FL_CMPA] <= 1'b1;
      end
      if (tick && pend_b) begin
        timer_flag_register[etc_pkg::FL_CMPB] <= 1'b1;
      end
    end
  end

  assign irq_req = timer_flag_register & timer_mask_register;

  // waveform outputs
  function automatic logic wave(input logic cur, input logic [1:0] com,
      input logic m);
    logic r;
    r = cur;
    if (m) begin
      case (com)
        etc_pkg::COM_TOGGLE: r = ~cur;
        etc_pkg::COM_CLEAR: r = 1'b0;
        etc_pkg::COM_SET: r = 1'b1;
        default: r = cur;
      endcase
    end
    return r;
  endfunction : wave

  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_output_pin_a <= 1'b0;
      compare_output_pin_b <= 1'b0;
    end else if (tick) begin
      if (buffered && !phase_correct && at_top) begin
        // fast pwm restarts the pulse at bottom
        compare_output_pin_a <= (ctrl.com_a == etc_pkg::COM_CLEAR);
        compare_output_pin_b <= (ctrl.com_b == etc_pkg::COM_CLEAR);
      end else begin
        compare_output_pin_a <= wave(compare_output_pin_a, ctrl.com_a,
            match_a & ~block_match);
        compare_output_pin_b <= wave(compare_output_pin_b, ctrl.com_b,
            match_b & ~block_match);
      end
    end
  end

  // wishbone answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= access & hit;
      wb_err_o <= access & ~hit;
      wb_dat_o <= '0;
      if (access && hit && !wb_we_i) begin
        case (wb_adr_i[4:0])
          etc_pkg::ADR_CTRL_A: wb_dat_o[7:0] <= {ctrl.com_a, ctrl.com_b,
              2'h0, ctrl.waveform_mode[1:0]};
          etc_pkg::ADR_CTRL_B: wb_dat_o[7:0] <= {4'h0,
              ctrl.waveform_mode[2], ctrl.clock_source_select};
          etc_pkg::ADR_COUNT: wb_dat_o[7:0] <= counter_value;
          etc_pkg::ADR_CMP_A: wb_dat_o[7:0] <= buffered ? buffer_a
              : compare_value_a;
          etc_pkg::ADR_CMP_B: wb_dat_o[7:0] <= buffered ? buffer_b
              : compare_value_b;
          etc_pkg::ADR_MASK: wb_dat_o[7:0] <= {5'h00, timer_mask_register};
          etc_pkg::ADR_FLAG: wb_dat_o[7:0] <= {5'h00, timer_flag_register};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule : etc_timer

// >>> etc_timer_monitor.sv
// port checker for the eight-bit timer, bound to its top module
`timescale 1ns/1ps
module etc_timer_monitor #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic timer_power_reduction,
  input wire logic external_count_pin,
  input wire logic [2:0] irq_ack,
  input wire logic [2:0] irq_req,
  input wire logic compare_output_pin_a,
  input wire logic compare_output_pin_b,
  input wire logic bottom,
  input wire logic top
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_wr(logic [4:0] a);
    s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == {27'h0, a});
  endsequence
  property p_answer;
    s_take |=> (wb_ack_o ^ wb_err_o);
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_unmapped;
    s_take ##0 (wb_adr_i > 32'h18) |=> wb_err_o && !wb_ack_o;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");
  property p_dat_width;
    !wb_ack_o || wb_dat_o[31:8] == 24'h0;
  endproperty
  a_dat_width: assert property (p_dat_width)
    else $error("read data wider than eight bits");
  // read data was captured from the counter seen one cycle before ack
  property p_extremes;
    s_take ##0 (!wb_we_i && wb_adr_i == {27'h0, etc_pkg::ADR_COUNT}) |=>
      ($past(bottom) == (wb_dat_o[7:0] == etc_pkg::CNT_BOTTOM))
      && ($past(top) == (wb_dat_o[7:0] == etc_pkg::CNT_MAX));
  endproperty
  a_extremes: assert property (p_extremes)
    else $error("bottom or top disagrees with counter read");
  property p_wr_zero;
    s_wr(etc_pkg::ADR_COUNT) ##0 wb_dat_i[7:0] == 8'h00 |=> bottom;
  endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("counter write of zero not bottom");
  property p_wr_max;
    s_wr(etc_pkg::ADR_COUNT) ##0 wb_dat_i[7:0] == 8'hFF |=> top && !bottom;
  endproperty
  a_wr_max: assert property (p_wr_max)
    else $error("counter write of max not top");
  property p_mask_off;
    s_wr(etc_pkg::ADR_MASK) ##0 wb_dat_i[2:0] == 3'h0 |=> irq_req == 3'h0;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("masked request still raised");
  // a bus write in the previous cycle may move the counter legally
  property p_held_off;
    timer_power_reduction && $past(timer_power_reduction) && !$past(rst)
      && !$past(wb_cyc_i) |-> $stable(bottom) && $stable(top);
  endproperty
  a_held_off: assert property (p_held_off)
    else $error("counter moved while powered down");
endmodule : etc_timer_monitor

bind etc_timer etc_timer_monitor #(.WIDTH(WIDTH)) i_etc_timer_monitor (
  .core_clk(core_clk), .rst(rst), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .timer_power_reduction(timer_power_reduction),
  .external_count_pin(external_count_pin), .irq_ack(irq_ack),
  .irq_req(irq_req), .compare_output_pin_a(compare_output_pin_a),
  .compare_output_pin_b(compare_output_pin_b), .bottom(bottom), .top(top)
);

// >>> etc_pin_model.sv
// far-side model: external count source and compare pin load
`timescale 1ns/1ps
module etc_pin_model (
  input wire logic core_clk,
  input wire logic compare_output_pin_a,
  input wire logic compare_output_pin_b,
  output logic external_count_pin
);
  // idles low; wide pulses so the 3-flop synchroniser sees each level
  initial external_count_pin = 1'b0;
  task automatic send_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge core_clk);
      external_count_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      external_count_pin <= 1'b0;
    end
  endtask : send_pulses
endmodule : etc_pin_model

// >>> test_eight_bit_timer_compare.sv
// register-level testbench for the eight-bit timer
`timescale 1ns/1ps
module test_eight_bit_timer_compare;
  logic core_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic timer_power_reduction, external_count_pin, bottom, top;
  logic [2:0] irq_ack, irq_req;
  logic pin_a, pin_b, re;
  logic [7:0] rq;
  int err_count = 0;
  int compares = 0;

  etc_timer #(.WIDTH(8)) i_etc_timer (
    .core_clk(core_clk), .rst(rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .timer_power_reduction(timer_power_reduction),
    .external_count_pin(external_count_pin), .irq_ack(irq_ack),
    .irq_req(irq_req), .compare_output_pin_a(pin_a),
    .compare_output_pin_b(pin_b), .bottom(bottom), .top(top));
  etc_pin_model i_etc_pin_model (
    .core_clk(core_clk), .compare_output_pin_a(pin_a),
    .compare_output_pin_b(pin_b), .external_count_pin(external_count_pin));

  task automatic complete_run;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic [4:0] a, input logic w,
                      input logic [7:0] d);
    int n;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= {27'h0, a};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("Error bus_wait expected ack seen none");
      complete_run();
    end
    rq = wb_dat_o[7:0];
    re = wb_err_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : xfer

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input string what, input logic [4:0] a,
                    input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(what, exp, rq);
  endtask : rd

  task automatic run_ticks(input int n);
    wr(etc_pkg::ADR_CTRL_B, {5'h0, etc_pkg::CS_DIV1});
    repeat (n) @(posedge core_clk);
    wr(etc_pkg::ADR_CTRL_B, {5'h0, etc_pkg::CS_STOP});
  endtask : run_ticks

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    irq_ack = 3'h0;
    timer_power_reduction = 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd("reset", 5'(i * 4), etc_pkg::RST_BYTE);
    xfer(5'h1C, 1'b0, 8'h00);
    chk("unmapped", 8'h01, {7'h0, re});
    chk("bottom", 8'h01, {7'h0, bottom});
    wr(etc_pkg::ADR_COUNT, 8'hFF);
    chk("top", 8'h01, {7'h0, top});
    wr(etc_pkg::ADR_CMP_A, 8'h80);
    wr(etc_pkg::ADR_CMP_B, 8'h81);
    repeat (20) @(posedge core_clk);
    rd("stopped", etc_pkg::ADR_COUNT, 8'hFF);
    rd("direct", etc_pkg::ADR_CMP_A, 8'h80);
    $display("test access done");
    wr(etc_pkg::ADR_MASK, 8'h07);
    wr(etc_pkg::ADR_COUNT, 8'hFD);
    run_ticks(20);
    rd("ovf", etc_pkg::ADR_FLAG, 8'h01);
    chk("ovf_irq", 8'h01, {5'h0, irq_req});
    irq_ack <= 3'h1;
    @(posedge core_clk);
    irq_ack <= 3'h0;
    rd("irq_ack", etc_pkg::ADR_FLAG, 8'h00);
    $display("test overflow done");
    wr(etc_pkg::ADR_COUNT, 8'h10);
    wr(etc_pkg::ADR_CMP_A, 8'h12);
    run_ticks(6);
    rd("cmp_flag", etc_pkg::ADR_FLAG, 8'h02);
    chk("cmp_irq", 8'h02, {5'h0, irq_req});
    wr(etc_pkg::ADR_FLAG, 8'h00);
    rd("w0_keeps", etc_pkg::ADR_FLAG, 8'h02);
    wr(etc_pkg::ADR_MASK, 8'h00);
    chk("masked", 8'h00, {5'h0, irq_req});
    wr(etc_pkg::ADR_FLAG, 8'h02);
    rd("w1_clears", etc_pkg::ADR_FLAG, 8'h00);
    $display("test compare done");
    // pin a toggles on each compare a match
    wr(etc_pkg::ADR_CTRL_A, {etc_pkg::COM_TOGGLE, 4'h0,
        etc_pkg::WM_CTC[1:0]});
    wr(etc_pkg::ADR_CMP_A, 8'h03);
    wr(etc_pkg::ADR_COUNT, 8'h00);
    // 30 ticks over a period of four: ends on two, seven matches
    run_ticks(27);
    rd("ctc_wrap", etc_pkg::ADR_COUNT, 8'h02);
    chk("wave", 8'h01, {6'h0, pin_b, pin_a});
    rd("ctc_flags", etc_pkg::ADR_FLAG, 8'h02);
    wr(etc_pkg::ADR_FLAG, 8'h07);
    $display("test ctc done");
    // buffered: the old active value 0x81 must stay in force mid-count
    wr(etc_pkg::ADR_CTRL_A, {6'h0, etc_pkg::WM_FAST_FF[1:0]});
    wr(etc_pkg::ADR_COUNT, 8'h30);
    wr(etc_pkg::ADR_CMP_B, 8'h31);
    rd("cmp_buf", etc_pkg::ADR_CMP_B, 8'h31);
    run_ticks(4);
    rd("no_load", etc_pkg::ADR_FLAG, 8'h00);
    wr(etc_pkg::ADR_CTRL_A, 8'h00);
    $display("test buffer done");
    wr(etc_pkg::ADR_COUNT, 8'h00);
    wr(etc_pkg::ADR_CTRL_B, {5'h0, etc_pkg::CS_EXT_RISE});
    i_etc_pin_model.send_pulses(5);
    repeat (8) @(posedge core_clk);
    rd("ext_rise", etc_pkg::ADR_COUNT, 8'h05);
    wr(etc_pkg::ADR_CTRL_B, {5'h0, etc_pkg::CS_EXT_FALL});
    i_etc_pin_model.send_pulses(3);
    repeat (8) @(posedge core_clk);
    rd("ext_fall", etc_pkg::ADR_COUNT, 8'h08);
    timer_power_reduction <= 1'b1;
    run_ticks(10);
    rd("held_off", etc_pkg::ADR_COUNT, 8'h08);
    timer_power_reduction <= 1'b0;
    $display("test external done");
    // phase correct: up to 0xFF then down; buffer b loads at top
    wr(etc_pkg::ADR_FLAG, 8'h07);
    wr(etc_pkg::ADR_CTRL_A, {6'h0, etc_pkg::WM_PC_FF[1:0]});
    wr(etc_pkg::ADR_COUNT, 8'hFD);
    wr(etc_pkg::ADR_CMP_B, 8'hF0);
    run_ticks(20);
    rd("pc_down", etc_pkg::ADR_COUNT, 8'hEA);
    rd("pc_load", etc_pkg::ADR_FLAG, 8'h04);
    $display("test phase done");
    complete_run();
  end
endmodule : test_eight_bit_timer_compare
